// ==== src/ccl_pkg.sv ====
package ccl_pkg;
  localparam logic [1:0] CCL_ADDR_SC = 2'h0;
  localparam logic [1:0] CCL_ADDR_IST = 2'h1;
  localparam logic [1:0] CCL_ADDR_IMSK = 2'h2;
  localparam int CCL_BIT_ON = 7;
  localparam int CCL_BIT_REFSEL = 6;
  localparam int CCL_BIT_FLAG = 5;
  localparam int CCL_BIT_IRQEN = 4;
  localparam int CCL_BIT_LEVEL = 3;
  localparam int CCL_BIT_PINEN = 2;
  localparam int CCL_MODE_HI = 1;
  localparam int CCL_MODE_LO = 0;
  localparam logic [7:0] CCL_SC_RESET = 8'h00;
  localparam logic [1:0] CCL_MODE_RISE = 2'h1;
  localparam logic [1:0] CCL_MODE_BOTH = 2'h3;
  localparam logic [1:0] CCL_EVT_RESET = 2'h0;
  localparam logic [1:0] CCL_MASK_RESET = 2'h0;
endpackage : ccl_pkg

// ==== src/ccl_top.sv ====
`timescale 1ns/1ps
module ccl_top
  import ccl_pkg::*;
(
  input wire logic sys_clk_in, // 40 MHz bus clock
  input wire logic reset_n_in, // Async reset, low
  input wire logic [1:0] addr_in, // Register index
  input wire logic [7:0] wdata_in, // Write data
  input wire logic wr_in, // Write strobe
  input wire logic rd_in, // Read strobe
  output logic [7:0] rdata_out, // Read data, cycle after strobe
  input wire logic cmp_raw_in, // Analog comparator output, async
  output logic ref_sel_out, // 1: bandgap to non-inverting input
  output logic cmp_en_out, // Powers the analog comparator
  output logic cmp_pin_out, // Comparator output pin level
  output logic cmp_pin_oe_out, // Output pin enable
  output logic cmp_irq_out, // Compare interrupt request
  output logic wake_req_out, // Stop wake-up request
  output logic evt_irq_out // Masked event interrupt, level
);
  // ==========================================
  // State
  typedef struct packed {
    logic [7:0] sc;
    logic sync1;
    logic sync2;
    logic lvl_prev;
    logic [1:0] evt;
    logic [1:0] mask;
    logic [7:0] rdata;
  } ccl_state_t;

  ccl_state_t s_reg, s_next;

  // ==========================================
  // Edge decode
  function automatic logic ccl_edge_hit(input logic [1:0] mode, input logic prev,
                                        input logic cur);
    logic rise;
    logic fall;
    rise = !prev && cur;
    fall = prev && !cur;
    unique case (mode)
      CCL_MODE_RISE: ccl_edge_hit = rise;
      CCL_MODE_BOTH: ccl_edge_hit = rise || fall;
      default: ccl_edge_hit = fall;
    endcase
  endfunction : ccl_edge_hit

  logic on;
  logic level;
  logic hit;
  logic flag_clr;
  logic sc_rd;
  logic ist_rd;

  // Debug halt has no input here, so the unit never stops for it
  assign on = s_reg.sc[CCL_BIT_ON];
  // Synchronised level only; first stage read by second alone
  assign level = on && s_reg.sync2;
  // Previous level forced low when off, so enabling on a high level counts as a rise
  assign hit = on && ccl_edge_hit(s_reg.sc[CCL_MODE_HI:CCL_MODE_LO], s_reg.lvl_prev,
                                  level);
  assign flag_clr = wr_in && addr_in == CCL_ADDR_SC && wdata_in[CCL_BIT_FLAG];
  assign sc_rd = rd_in && addr_in == CCL_ADDR_SC;
  assign ist_rd = rd_in && addr_in == CCL_ADDR_IST;

  always_comb begin
    s_next = s_reg;
    s_next.sync1 = cmp_raw_in;
    s_next.sync2 = s_reg.sync1;
    s_next.lvl_prev = level;
    if (wr_in && addr_in == CCL_ADDR_SC) begin
      s_next.sc[CCL_BIT_ON] = wdata_in[CCL_BIT_ON];
      s_next.sc[CCL_BIT_REFSEL] = wdata_in[CCL_BIT_REFSEL];
      s_next.sc[CCL_BIT_IRQEN] = wdata_in[CCL_BIT_IRQEN];
      s_next.sc[CCL_BIT_PINEN] = wdata_in[CCL_BIT_PINEN];
      s_next.sc[CCL_MODE_HI:CCL_MODE_LO] = wdata_in[CCL_MODE_HI:CCL_MODE_LO];
    end
    if (wr_in && addr_in == CCL_ADDR_IMSK) begin
      s_next.mask = wdata_in[1:0];
    end
    // Set beats clear in the same cycle
    if (flag_clr) begin
      s_next.sc[CCL_BIT_FLAG] = 1'b0;
    end
    if (hit) begin
      s_next.sc[CCL_BIT_FLAG] = 1'b1;
    end
    s_next.sc[CCL_BIT_LEVEL] = 1'b0;
    // Sticky events: bit0 compare event, bit1 flag cleared by software
    if (ist_rd) begin
      s_next.evt = 2'h0;
    end
    if (hit) begin
      s_next.evt[0] = 1'b1;
    end
    if (flag_clr) begin
      s_next.evt[1] = 1'b1;
    end
    s_next.rdata = 8'h00;
    if (sc_rd) begin
      s_next.rdata = s_reg.sc;
      s_next.rdata[CCL_BIT_LEVEL] = level;
    end else if (ist_rd) begin
      s_next.rdata = {6'h00, s_reg.evt};
    end else if (rd_in && addr_in == CCL_ADDR_IMSK) begin
      s_next.rdata = {6'h00, s_reg.mask};
    end
  end

  // Reset also covers deep-stop wake and stop exit by reset
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      s_reg <= '0;
      s_reg.sc <= CCL_SC_RESET;
      s_reg.evt <= CCL_EVT_RESET;
      s_reg.mask <= CCL_MASK_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  // ==========================================
  // Outputs
  assign rdata_out = s_reg.rdata;
  assign ref_sel_out = s_reg.sc[CCL_BIT_REFSEL];
  assign cmp_en_out = on;
  assign cmp_pin_oe_out = on && s_reg.sc[CCL_BIT_PINEN];
  assign cmp_pin_out = cmp_pin_oe_out && level;
  assign cmp_irq_out = s_reg.sc[CCL_BIT_IRQEN] && s_reg.sc[CCL_BIT_FLAG];
  assign wake_req_out = cmp_irq_out;
  assign evt_irq_out = |(s_reg.evt & s_reg.mask);

  // ==========================================
  // Checks
  sequence s_clear_write;
    wr_in && addr_in == CCL_ADDR_SC && wdata_in[CCL_BIT_FLAG] && !hit;
  endsequence

  property p_flag_set;
    @(posedge sys_clk_in) disable iff (!reset_n_in) hit |=> s_reg.sc[CCL_BIT_FLAG];
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("flag not set");

  property p_flag_clr;
    @(posedge sys_clk_in) disable iff (!reset_n_in) s_clear_write |=> !s_reg.sc[CCL_BIT_FLAG];
  endproperty
  a_flag_clr: assert property (p_flag_clr) else $error("flag not cleared");

  property p_flag_hold;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
      s_reg.sc[CCL_BIT_FLAG] && !flag_clr |=> s_reg.sc[CCL_BIT_FLAG];
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("flag lost");

  property p_irq;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
      cmp_irq_out == (s_reg.sc[CCL_BIT_IRQEN] && s_reg.sc[CCL_BIT_FLAG]);
  endproperty
  a_irq: assert property (p_irq) else $error("irq mismatch");

  property p_level_read;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
      sc_rd |=> rdata_out[CCL_BIT_LEVEL] == $past(level);
  endproperty
  a_level_read: assert property (p_level_read) else $error("level read wrong");

  property p_level_off;
    @(posedge sys_clk_in) disable iff (!reset_n_in) sc_rd && !on |=> !rdata_out[CCL_BIT_LEVEL];
  endproperty
  a_level_off: assert property (p_level_off) else $error("level not zero when off");

  property p_pin;
    @(posedge sys_clk_in) disable iff (!reset_n_in) !s_reg.sc[CCL_BIT_PINEN] |-> !cmp_pin_oe_out;
  endproperty
  a_pin: assert property (p_pin) else $error("pin driven while disabled");

  property p_rise;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
      on && s_reg.sc[CCL_MODE_HI:CCL_MODE_LO] == CCL_MODE_RISE && !level ##1
      on && level && $stable(s_reg.sc[CCL_MODE_HI:CCL_MODE_LO]) |=> s_reg.sc[CCL_BIT_FLAG];
  endproperty
  a_rise: assert property (p_rise) else $error("rising edge missed");

  property p_sync;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
      on ##1 on && $stable(on) |-> level == $past(cmp_raw_in, 2);
  endproperty
  a_sync: assert property (p_sync) else $error("sync depth wrong");

  // ==========================================
  // Edge and event checks
  // Levels are taken after the unit gate, so an off unit never looks high
  sequence s_level_high;
    on && level;
  endsequence

  sequence s_level_low;
    on && !level;
  endsequence

  property p_fall;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
      s_level_high ##1 s_level_low ##0 !s_reg.sc[CCL_MODE_LO] |=> s_reg.sc[CCL_BIT_FLAG];
  endproperty
  a_fall: assert property (p_fall) else $error("falling edge missed");

  property p_rise_only;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
      !s_reg.sc[CCL_BIT_FLAG] ##0 s_level_high ##1 s_level_low ##0
      s_reg.sc[CCL_MODE_HI:CCL_MODE_LO] == CCL_MODE_RISE |=> !s_reg.sc[CCL_BIT_FLAG];
  endproperty
  a_rise_only: assert property (p_rise_only) else $error("falling edge flagged");

  property p_both;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
      on && s_reg.sc[CCL_MODE_HI:CCL_MODE_LO] == CCL_MODE_BOTH && $changed(level) |=> s_reg.sc[CCL_BIT_FLAG];
  endproperty
  a_both: assert property (p_both) else $error("toggle missed");

  // An off unit must never raise the flag on its own
  property p_off_quiet;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
      !on && !flag_clr |=> $stable(s_reg.sc[CCL_BIT_FLAG]);
  endproperty
  a_off_quiet: assert property (p_off_quiet) else $error("flag moved while off");

  property p_off_level;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
      !on |-> !level;
  endproperty
  a_off_level: assert property (p_off_level) else $error("level seen while off");

  property p_level_ro;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
      wr_in && addr_in == CCL_ADDR_SC |=> !s_reg.sc[CCL_BIT_LEVEL];
  endproperty
  a_level_ro: assert property (p_level_ro) else $error("level bit written");

  // ==========================================
  // Control and output checks
  property p_en;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
      wr_in && addr_in == CCL_ADDR_SC |=> cmp_en_out == $past(wdata_in[CCL_BIT_ON]);
  endproperty
  a_en: assert property (p_en) else $error("enable not taken");

  property p_ref_sel;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
      wr_in && addr_in == CCL_ADDR_SC |=> ref_sel_out == $past(wdata_in[CCL_BIT_REFSEL]);
  endproperty
  a_ref_sel: assert property (p_ref_sel) else $error("reference select not taken");

  property p_pin_level;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
      cmp_pin_oe_out |-> cmp_pin_out == level;
  endproperty
  a_pin_level: assert property (p_pin_level) else $error("pin level wrong");

  property p_irq_off;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
      !s_reg.sc[CCL_BIT_IRQEN] |-> !cmp_irq_out;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("irq while disabled");

  // Wake-up must follow an event even while the bus side is idle
  property p_wake;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
      s_reg.sc[CCL_BIT_IRQEN] && hit && !(wr_in && addr_in == CCL_ADDR_SC) |=> wake_req_out;
  endproperty
  a_wake: assert property (p_wake) else $error("wake-up missing");

  // ==========================================
  // Bus and event status checks
  property p_rd_idle;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
      !rd_in |=> rdata_out == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside its cycle");

  property p_rd_ctrl;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
      sc_rd |=> rdata_out[7:4] == $past(s_reg.sc[7:4]);
  endproperty
  a_rd_ctrl: assert property (p_rd_ctrl) else $error("control read wrong");

  property p_evt_set;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
      hit |=> s_reg.evt[0];
  endproperty
  a_evt_set: assert property (p_evt_set) else $error("event status not set");

  property p_evt_clear;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
      ist_rd && !hit && !flag_clr |=> s_reg.evt == 2'h0;
  endproperty
  a_evt_clear: assert property (p_evt_clear) else $error("event status not cleared");

  property p_mask_wr;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
      wr_in && addr_in == CCL_ADDR_IMSK |=> s_reg.mask == $past(wdata_in[1:0]);
  endproperty
  a_mask_wr: assert property (p_mask_wr) else $error("mask not written");

  property p_evt_irq;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
      s_reg.evt[0] && s_reg.mask[0] |-> evt_irq_out;
  endproperty
  a_evt_irq: assert property (p_evt_irq) else $error("event irq missing");
endmodule : ccl_top

// ==== bench/ccl_cmp_model.sv ====
`timescale 1ns/1ps
// ====================================
// Analog comparator core
module ccl_cmp_model #(
  parameter logic [15:0] BG_MV = 16'h04b0 // Bandgap level, plain default
) (
  input wire logic en_in, // Comparator powered
  input wire logic ref_sel_in, // Bandgap to non-inverting input
  input wire logic [15:0] plus_mv_in, // Plus pin voltage
  input wire logic [15:0] minus_mv_in, // Minus pin voltage
  output logic raw_out // Comparator decision
);
  logic [15:0] noninv;
  assign noninv = ref_sel_in ? BG_MV : plus_mv_in;
  // Unpowered core idles low, so no stale decision leaks out
  assign raw_out = en_in && (noninv > minus_mv_in);
endmodule : ccl_cmp_model

// ==== bench/test_comparator_control_logic.sv ====
`timescale 1ns/1ps
module test_comparator_control_logic;
  import ccl_pkg::*;
  logic sys_clk_in, reset_n_in, wr_in, rd_in, cmp_raw_in;
  logic [1:0] addr_in;
  logic [7:0] wdata_in, rdata_out;
  logic ref_sel_out, cmp_en_out, cmp_pin_out, cmp_pin_oe_out;
  logic cmp_irq_out, wake_req_out, evt_irq_out;
  logic [15:0] plus_mv, minus_mv;
  int n_mismatch, n_checks;
  ccl_top dut_u (.sys_clk_in, .reset_n_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out,
    .cmp_raw_in, .ref_sel_out, .cmp_en_out, .cmp_pin_out, .cmp_pin_oe_out, .cmp_irq_out,
    .wake_req_out, .evt_irq_out);
  ccl_cmp_model core_u (.en_in(cmp_en_out), .ref_sel_in(ref_sel_out), .plus_mv_in(plus_mv),
    .minus_mv_in(minus_mv), .raw_out(cmp_raw_in));
  // ====================================
  // Bus and compare tasks
  task automatic end_sim();
    $display("Counts: %0d checks, %0d mismatches", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : end_sim
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge sys_clk_in);
    wr_in <= 1'b1;
    addr_in <= a;
    wdata_in <= d;
    @(posedge sys_clk_in);
    wr_in <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [1:0] a, input logic [7:0] exp);
    @(posedge sys_clk_in);
    rd_in <= 1'b1;
    addr_in <= a;
    @(posedge sys_clk_in);
    rd_in <= 1'b0;
    #1;
    chk(rdata_out, exp);
  endtask : rd
  // Waits out the two-stage sync plus the flag update
  task automatic drive(input logic [15:0] p, input logic [15:0] m);
    @(posedge sys_clk_in);
    plus_mv <= p;
    minus_mv <= m;
    repeat (4) @(posedge sys_clk_in);
    #1;
  endtask : drive
  // ====================================
  // Clock, watchdog, tests
  initial begin
    sys_clk_in = 1'b0;
    forever #12.5 sys_clk_in = ~sys_clk_in;
  end
  initial begin
    repeat (6000) @(posedge sys_clk_in);
    n_mismatch++;
    end_sim();
  end
  initial begin
    reset_n_in = 1'b0;
    wr_in = 1'b0;
    rd_in = 1'b0;
    addr_in = 2'h0;
    wdata_in = 8'h00;
    plus_mv = 16'h0800;
    minus_mv = 16'h0400;
    repeat (5) @(posedge sys_clk_in);
    reset_n_in <= 1'b1;
    rd(CCL_ADDR_SC, CCL_SC_RESET);
    wr(CCL_ADDR_SC, 8'h91);
    drive(16'h0800, 16'h0400);
    rd(CCL_ADDR_SC, 8'hb9);
    chk({5'h0, cmp_en_out, cmp_irq_out, wake_req_out}, 8'h07);
    wr(CCL_ADDR_SC, 8'h91);
    rd(CCL_ADDR_SC, 8'hb9);
    wr(CCL_ADDR_SC, 8'hb1);
    rd(CCL_ADDR_SC, 8'h99);
    chk({7'h0, cmp_irq_out}, 8'h00);
    $display("Test enable and flag done");
    for (logic [2:0] m = 3'h0; m < 3'h4; m++) begin
      wr(CCL_ADDR_SC, {6'h28, m[1:0]});
      drive(16'h0400, 16'h0800);
      rd(CCL_ADDR_SC, {2'h2, m[1:0] != 2'h1, 3'h0, m[1:0]});
      wr(CCL_ADDR_SC, {6'h28, m[1:0]});
      drive(16'h0800, 16'h0400);
      rd(CCL_ADDR_SC, {2'h2, m[0], 2'h1, 1'b0, m[1:0]});
    end
    $display("Test event modes done");
    drive(16'h0100, 16'h0400);
    wr(CCL_ADDR_SC, 8'he4);
    drive(16'h0100, 16'h0400);
    rd(CCL_ADDR_SC, 8'hcc);
    chk({5'h0, ref_sel_out, cmp_pin_oe_out, cmp_pin_out}, 8'h07);
    wr(CCL_ADDR_SC, 8'h80);
    drive(16'h0100, 16'h0400);
    chk({6'h0, cmp_pin_oe_out, cmp_pin_out}, 8'h00);
    $display("Test reference and pin done");
    rd(CCL_ADDR_IST, 8'h03);
    rd(CCL_ADDR_IST, 8'h00);
    wr(CCL_ADDR_IMSK, 8'h01);
    rd(CCL_ADDR_IMSK, 8'h01);
    wr(CCL_ADDR_SC, 8'h83);
    chk({7'h0, evt_irq_out}, 8'h00);
    drive(16'h0800, 16'h0400);
    chk({7'h0, evt_irq_out}, 8'h01);
    rd(CCL_ADDR_IST, 8'h01);
    chk({7'h0, evt_irq_out}, 8'h00);
    rd(2'h3, 8'h00);
    $display("Test event status done");
    wr(CCL_ADDR_SC, 8'h03);
    rd(CCL_ADDR_SC, 8'h23);
    @(posedge sys_clk_in);
    reset_n_in <= 1'b0;
    repeat (2) @(posedge sys_clk_in);
    reset_n_in <= 1'b1;
    rd(CCL_ADDR_SC, CCL_SC_RESET);
    $display("Test disable and reset done");
    end_sim();
  end
endmodule : test_comparator_control_logic
